// ==== tb/puio_chk_asserts.sv ====
// Checker for the pump user I/O block
`timescale 1ns/1ps
module puio_chk(
   // Inputs
   input wire core_clk,
   input wire rst,
   input wire dir_pin,
   input wire trig_pin,
   input wire ss_pin,
   input wire [1:0] ss_mode,
   input wire trig_out_set,
   input wire trig_out_val,
   // Outputs
   input wire trig_out,
   input wire run_ind_n,
   input wire pump_dir,
   input wire running,
   input wire prog_event
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_go; $rose(running); endsequence
   property p_ind; run_ind_n == !running; endproperty
   a_ind: assert property (p_ind) else $error("ind");
   property p_to; trig_out_set |=> trig_out == $past(trig_out_val); endproperty
   a_to: assert property (p_to) else $error("tout");
   property p_ev1; prog_event |=> !prog_event; endproperty
   a_ev1: assert property (p_ev1) else $error("ev1");
   property p_ev; prog_event |-> !$past(trig_pin, 3); endproperty
   a_ev: assert property (p_ev) else $error("ev");
   property p_dir; $changed(pump_dir) |-> pump_dir == $past(dir_pin, 3); endproperty
   a_dir: assert property (p_dir) else $error("dir");
   property p_tg; ss_mode == 2'h0 && $changed(running) |-> !$past(ss_pin, 3); endproperty
   a_tg: assert property (p_tg) else $error("tog");
   property p_rs; ss_mode == 2'h1 ##0 s_go |-> $past(ss_pin, 3); endproperty
   a_rs: assert property (p_rs) else $error("rs");
   property p_fs; ss_mode == 2'h2 ##0 s_go |-> !$past(ss_pin, 3); endproperty
   a_fs: assert property (p_fs) else $error("fs");
endmodule
bind puio_top puio_chk chk_u(.*);

// ==== tb/puio_ttl.sv ====
// Model of the external source on the user pins
`timescale 1ns/1ps
module puio_ttl(
   // Clock and pins
   input wire core_clk,
   output reg [2:0] pins
);
   // Pins idle high
   initial pins = 3'h7;
   // Set one pin, hold past the filter
   task drive(input integer p, input reg v);
   begin
      @(negedge core_clk);
      pins[p] = v;
      repeat (20) @(negedge core_clk);
   end
   endtask
   // Short pulse of n cycles that the filter must reject
   task glitch(input integer p, input reg v, input integer n);
   begin
      @(negedge core_clk);
      pins[p] = v;
      repeat (n) @(negedge core_clk);
      pins[p] = ~v;
      repeat (20) @(negedge core_clk);
   end
   endtask
endmodule

// ==== tb/tb_top.sv ====
// Bench for the pump user I/O block
`timescale 1ns/1ps
module tb_top;
   reg core_clk = 0, rst = 1, trig_out_set = 0, trig_out_val = 0, lr = 0, ld = 1;
   reg [1:0] ss_mode = 2'h0;
   reg run_stop_req = 0;
   reg [2:0] x;
   reg [2:0] exp_q[$];
   integer error_cnt = 0, tests_run = 0, i;
   wire [2:0] pins;
   wire dir_pin = pins[0], trig_pin = pins[1], ss_pin = pins[2];
   wire trig_out, run_ind_n, pump_dir, running, prog_event;
   always #5 core_clk = ~core_clk;
   puio_ttl ttl_u(.core_clk(core_clk), .pins(pins));
   puio_top #(.FILT_CYC(4), .CW(3)) dut_u(.core_clk(core_clk), .rst(rst), .dir_pin(dir_pin),
      .trig_pin(trig_pin), .ss_pin(ss_pin), .ss_mode(ss_mode), .trig_out_set(trig_out_set),
      .trig_out_val(trig_out_val), .run_stop_req(run_stop_req), .trig_out(trig_out),
      .run_ind_n(run_ind_n), .pump_dir(pump_dir), .running(running), .prog_event(prog_event));
   // Compare and count
   task chk(input [2:0] g, input [2:0] x);
   begin
      tests_run = tests_run + 1;
      if (g !== x)
      begin
         error_cnt = error_cnt + 1;
         $display("Error %0t: %h not %h", $time, g, x);
      end
   end
   endtask
   // Report and stop
   task print_verdict;
   begin
      $display("runs %0d errors %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   // Note a result unless 7, then drive a pin
   task st(input integer p, input reg v, input [2:0] r);
   begin
      if (r != 3'h7)
         exp_q.push_back(r);
      ttl_u.drive(p, v);
   end
   endtask
   // Oldest note against each output change
   always @(negedge core_clk)
      if (prog_event || running !== lr || pump_dir !== ld)
      begin
         x = exp_q.size() ? exp_q.pop_front() : 3'hx;
         chk({prog_event, running, pump_dir}, x);
         chk({2'h0, run_ind_n}, {2'h0, ~x[1]});
         lr = running;
         ld = pump_dir;
      end
   // Main sequence
   initial
   begin
      i = $urandom(32'hd2d8);
      repeat (6) @(negedge core_clk);
      rst = 0;
      chk({2'h0, trig_out}, 3'h0);
      st(0, 0, 3'h0);
      st(0, 1, 3'h1);
      st(1, 0, 3'h5);
      st(1, 1, 3'h7);
      st(2, 0, 3'h3);
      st(2, 1, 3'h7);
      st(2, 0, 3'h1);
      ss_mode = 2'h1;
      st(2, 1, 3'h3);
      st(2, 0, 3'h1);
      ss_mode = 2'h2;
      st(2, 1, 3'h7);
      st(2, 0, 3'h3);
      st(2, 1, 3'h1);
      // Mode 3 ignores the pin; a short trigger glitch gives no event
      ss_mode = 2'h3;
      st(2, 0, 3'h7);
      st(2, 1, 3'h7);
      ttl_u.glitch(1, 0, 3);
      // Controller run request flips the run state
      exp_q.push_back(3'h3);
      run_stop_req = 1;
      @(negedge core_clk);
      run_stop_req = 0;
      // Loaded trigger levels, then hold with load low
      trig_out_set = 1;
      repeat (4)
      begin
         i = $urandom;
         trig_out_val = i[0];
         @(negedge core_clk);
         chk({2'h0, trig_out}, {2'h0, trig_out_val});
      end
      trig_out_val = 1;
      @(negedge core_clk);
      chk({2'h0, trig_out}, 3'h1);
      trig_out_set = 0;
      trig_out_val = 0;
      @(negedge core_clk);
      chk({2'h0, trig_out}, 3'h1);
      // Mid-run reset stops the pump and drives the trigger output low
      exp_q.push_back(3'h1);
      rst = 1;
      repeat (2) @(negedge core_clk);
      chk({2'h0, trig_out}, 3'h0);
      rst = 0;
      repeat (8) @(negedge core_clk);
      chk({2'h0, exp_q.size() != 0}, 3'h0);
      print_verdict;
   end
endmodule

// ==== verilog/puio_filter.v ====
// Synchroniser, stability filter and edge detector for one user input
`timescale 1ns/1ps
module puio_filter
#(
   parameter FILT_CYC = 100000,
   parameter CW = 17
)
(
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // Raw pin
   input wire pin,
   // Filtered level and edges
   output reg level,
   output reg rise,
   output reg fall
);

reg sync_a;
reg sync_b;
reg [CW-1:0] cnt;

// Two-stage synchroniser
always @(posedge core_clk or posedge rst)
begin
   if (rst)
   begin
      sync_a <= 1'h1;
      sync_b <= 1'h1;
   end
   else
   begin
      sync_a <= pin;
      sync_b <= sync_a;
   end
end

// Accept a new level only after it stays stable for FILT_CYC cycles
always @(posedge core_clk or posedge rst)
begin
   if (rst)
   begin
      cnt <= {CW{1'b0}};
      level <= 1'h1;
      rise <= 1'h0;
      fall <= 1'h0;
   end
   else
   begin
      rise <= 1'h0;
      fall <= 1'h0;
      if (sync_b == level)
      begin
         cnt <= {CW{1'b0}};
      end
      else if (cnt == FILT_CYC[CW-1:0] - {{(CW-1){1'b0}}, 1'b1})
      begin
         cnt <= {CW{1'b0}};
         level <= sync_b;
         rise <= sync_b;
         fall <= ~sync_b;
      end
      else
      begin
         cnt <= cnt + {{(CW-1){1'b0}}, 1'b1};
      end
   end
end

endmodule

// ==== verilog/puio_regs.vh ====
// Constants for the pump user I/O block
`ifndef PUIO_REGS_VH
`define PUIO_REGS_VH
// Start/stop behaviour codes
`define PUIO_MODE_TOGGLE 2'h0
`define PUIO_MODE_RISE_START 2'h1
`define PUIO_MODE_FALL_START 2'h2
`define PUIO_MODE_RESET 2'h0
// Direction codes
`define PUIO_DIR_REFILL 1'h0
`define PUIO_DIR_INFUSE 1'h1
// Input filter time in microseconds, and clock rate in MHz
`define PUIO_FILT_US 1000
`define PUIO_CLK_MHZ 100
`define PUIO_FILT_CYC (`PUIO_FILT_US * `PUIO_CLK_MHZ)
`endif

// ==== verilog/puio_top.v ====
// Edge-driven user I/O logic of a syringe pump controller
`timescale 1ns/1ps
`include "puio_regs.vh"

////////////////////////////////////////////////////////////////////////////////
module puio_top
#(
   parameter FILT_CYC = `PUIO_FILT_CYC,
   parameter CW = 17
)
(
   // Clock and reset
   input wire core_clk,
   input wire rst,
   // User input pins
   input wire dir_pin,
   input wire trig_pin,
   input wire ss_pin,
   // Configuration
   input wire [1:0] ss_mode,
   // Trigger output control from program or serial command
   input wire trig_out_set,
   input wire trig_out_val,
   // Run control from the rest of the controller
   input wire run_stop_req,
   // Outputs
   output reg trig_out,
   output wire run_ind_n,
   output reg pump_dir,
   output reg running,
   output reg prog_event
);

// Internal signals
wire dir_rise;
wire dir_fall;
wire trig_rise;
wire trig_fall;
wire ss_rise;
wire ss_fall;
reg next_running;
reg [1:0] mode;
reg run_ind_q;

////////////////////////////////////////////////////////////////////////////////
// Input conditioning
puio_filter #(.FILT_CYC(FILT_CYC), .CW(CW)) u_dir
(
   .core_clk(core_clk),
   .rst(rst),
   .pin(dir_pin),
   .level(),
   .rise(dir_rise),
   .fall(dir_fall)
);

puio_filter #(.FILT_CYC(FILT_CYC), .CW(CW)) u_trig
(
   .core_clk(core_clk),
   .rst(rst),
   .pin(trig_pin),
   .level(),
   .rise(trig_rise),
   .fall(trig_fall)
);

puio_filter #(.FILT_CYC(FILT_CYC), .CW(CW)) u_ss
(
   .core_clk(core_clk),
   .rst(rst),
   .pin(ss_pin),
   .level(),
   .rise(ss_rise),
   .fall(ss_fall)
);

////////////////////////////////////////////////////////////////////////////////
// Mode register, toggle behaviour straight out of reset
always @(posedge core_clk or posedge rst)
begin
   if (rst)
   begin
      mode <= `PUIO_MODE_RESET;
   end
   else
   begin
      mode <= ss_mode;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Direction register
always @(posedge core_clk or posedge rst)
begin
   if (rst)
   begin
      pump_dir <= `PUIO_DIR_INFUSE;
   end
   else if (dir_rise)
   begin
      pump_dir <= `PUIO_DIR_INFUSE;
   end
   else if (dir_fall)
   begin
      pump_dir <= `PUIO_DIR_REFILL;
   end
end

// Program event pulse on falling trigger edge only
always @(posedge core_clk or posedge rst)
begin
   if (rst)
   begin
      prog_event <= 1'h0;
   end
   else
   begin
      prog_event <= trig_fall;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Start/stop decode per latched mode; code 3 leaves the pin without effect
always @*
begin
   next_running = running;
   case (mode)
      `PUIO_MODE_TOGGLE:
      begin
         if (ss_fall)
         begin
            next_running = ~running;
         end
      end
      `PUIO_MODE_RISE_START:
      begin
         if (ss_rise)
         begin
            next_running = 1'h1;
         end
         else if (ss_fall)
         begin
            next_running = 1'h0;
         end
      end
      `PUIO_MODE_FALL_START:
      begin
         if (ss_fall)
         begin
            next_running = 1'h1;
         end
         else if (ss_rise)
         begin
            next_running = 1'h0;
         end
      end
      default:
      begin
         next_running = running;
      end
   endcase
   // Internal run/stop request flips state when no pin edge changes it
   if (run_stop_req && (next_running == running))
   begin
      next_running = ~running;
   end
end

// Run state
always @(posedge core_clk or posedge rst)
begin
   if (rst)
   begin
      running <= 1'h0;
   end
   else
   begin
      running <= next_running;
   end
end

// Trigger output, low from reset
always @(posedge core_clk or posedge rst)
begin
   if (rst)
   begin
      trig_out <= 1'h0;
   end
   else if (trig_out_set)
   begin
      trig_out <= trig_out_val;
   end
end

////////////////////////////////////////////////////////////////////////////////
// Run indicator flop, switches on the same edge as the run state
always @(posedge core_clk or posedge rst)
begin
   if (rst)
   begin
      run_ind_q <= 1'h1;
   end
   else
   begin
      run_ind_q <= ~next_running;
   end
end

// Active-low run indicator, low while running
assign run_ind_n = run_ind_q;

endmodule
